// [hw/smc_standby_ctrl.sv]
// Register access over APB was decided locally.
`timescale 1ns/1ps
module smc_standby_ctrl
   import smc_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_pending,
   input wire logic stop_wake,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic full_periph_en,
   output logic hs_clk_en,
   output logic system_clock_hs,
   output logic vddl_low,
   output logic adc_block_reset,
   output logic run_mode
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W < 18 || ADDR_W > 32) begin : g_chk
      $error("smc_standby_ctrl: ADDR_W must be 18 to 32");
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [15:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction : hit

   smc_state_e state_ff; // operating state
   smc_state_e nxt_state;
   logic [15:0] prst3_ff; // peripheral reset register 3
   logic drm_ff; // deep mode select
   logic dpm_ff; // deep power select
   logic sel_ff; // software clock source select
   logic saved_sel_ff; // source held across standby
   logic key1_ff; // first unlock code seen
   logic unlk_ff; // stop unlocked
   logic refused_ff; // last entry request refused
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic cpu_ff, per_ff, full_ff, hs_ff, shs_ff, vddl_ff, run_ff;

   wire setup = psel & ~penable; // setup phase
   wire acc = psel & penable & pready_ff; // access completes
   wire wr = acc & pwrite;
   wire h_prst = hit(paddr, SMC_IDX_PRST3);
   wire h_sbyc = hit(paddr, SMC_IDX_SBYC);
   wire h_unlk = hit(paddr, SMC_IDX_UNLK);
   wire h_clks = hit(paddr, SMC_IDX_CLKS);
   wire h_stat = hit(paddr, SMC_IDX_STAT);
   wire mapped = h_prst | h_sbyc | h_unlk | h_clks | h_stat;
   wire wr_sbyc = wr & h_sbyc & pstrb[0];
   wire wr_unlk = wr & h_unlk & pstrb[0];
   wire in_run = (state_ff == SMC_RUN);

   // ------------------------------------------------------------
   // entry request decode
   // ------------------------------------------------------------
   wire req_hlt = pwdata[SMC_B_HLT];
   wire req_high_speed_halt_request_bit = pwdata[SMC_B_HIGH_SPEED_HALT_REQUEST_BIT];
   wire req_stp = pwdata[SMC_B_STP];
   wire req_drm = pwdata[SMC_B_DRM];
   // requesting two modes at once is not an entry
   wire req_one = (32'(req_hlt) + 32'(req_high_speed_halt_request_bit) + 32'(req_stp)) == 32'h1;
   wire req_any = req_hlt | req_high_speed_halt_request_bit | req_stp;
   // high-speed halt refused on low clock
   wire high_speed_halt_request_bit_ok = req_high_speed_halt_request_bit & sel_ff;
   wire stp_ok = req_stp & unlk_ff;
   wire kind_ok = req_hlt | high_speed_halt_request_bit_ok | stp_ok;
   // pending interrupt cancels the entry
   wire enter = wr_sbyc & in_run & req_one & kind_ok
      & ~irq_pending;
   wire refuse = wr_sbyc & in_run & req_any & ~enter;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SMC_RST: nxt_state = SMC_RUN;
         SMC_RUN: begin
            if (enter && req_hlt && !req_drm) begin
               nxt_state = SMC_HALT;
            end else if (enter && req_hlt) begin
               nxt_state = SMC_HALTD;
            end else if (enter && req_high_speed_halt_request_bit) begin
               nxt_state = SMC_HALTH;
            end else if (enter && req_stp && req_drm) begin
               nxt_state = SMC_STOPD;
            end else if (enter) begin
               nxt_state = SMC_STOP;
            end
         end
         // halt family wakes on watchdog or enabled interrupt
         SMC_HALT, SMC_HALTH, SMC_HALTD: begin
            if (irq_pending) begin
               nxt_state = SMC_RUN;
            end
         end
         // stop family wakes on its own sources only
         SMC_STOP, SMC_STOPD: begin
            if (stop_wake) begin
               nxt_state = SMC_RUN;
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // clock source after the next state
   // ------------------------------------------------------------
   logic nxt_sel;
   always_comb begin
      nxt_sel = sel_ff;
      if (wr & h_clks & pstrb[0]) begin
         nxt_sel = pwdata[SMC_B_SEL];
      end
      if (state_ff == SMC_HALTH && nxt_state == SMC_RUN) begin
         nxt_sel = 1'b1;
      end else if (state_ff != SMC_RUN && state_ff != SMC_RST
                   && nxt_state == SMC_RUN) begin
         nxt_sel = saved_sel_ff;
      end
   end

   // ------------------------------------------------------------
   // clock gating per state
   // ------------------------------------------------------------
   wire n_run = (nxt_state == SMC_RUN);
   wire n_halt = (nxt_state == SMC_HALT);
   wire n_halth = (nxt_state == SMC_HALTH);
   wire n_haltd = (nxt_state == SMC_HALTD);
   wire n_stpx = (nxt_state == SMC_STOP) | (nxt_state == SMC_STOPD);
   // cpu clock runs only in run mode
   wire nxt_cpu = n_run;
   // peripherals clocked in all but reset and the stop family
   wire nxt_per = ~n_stpx & (nxt_state != SMC_RST);
   // deep halt keeps only a subset of peripherals
   wire nxt_full = n_run | n_halt | n_halth;
   // high clocks off in high-speed halt, deep halt, stop
   wire nxt_hs = (n_run & nxt_sel) | (n_halt & nxt_sel);
   // system clock source: low clock while high clocks are off
   wire nxt_shs = nxt_hs;
   wire nxt_vddl = (nxt_state == SMC_STOPD);

   // ------------------------------------------------------------
   // read data mux
   // ------------------------------------------------------------
   wire [31:0] rd_prst = {16'h0000, prst3_ff};
   wire [31:0] rd_sbyc = 32'({dpm_ff, drm_ff}) << SMC_B_DRM;
   wire [31:0] rd_clks = 32'(sel_ff);
   wire [31:0] rd_stat = 32'(state_ff)
      | (32'(unlk_ff) << SMC_B_UNLK) | (32'(refused_ff) << SMC_B_REFU);
   wire [31:0] rd_mux = h_prst ? rd_prst :
                        h_sbyc ? rd_sbyc :
                        h_clks ? rd_clks :
                        h_stat ? rd_stat : 32'h00000000;

   // ------------------------------------------------------------
   // bus handshake: no wait state, answer in first access cycle
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup & ~mapped;
         prdata_ff <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // state and software registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_ff <= SMC_RST;
         sel_ff <= SMC_RST_SEL;
         saved_sel_ff <= SMC_RST_SEL;
      end else begin
         state_ff <= nxt_state;
         sel_ff <= nxt_sel;
         // remember the source at entry
         if (enter) begin
            saved_sel_ff <= sel_ff;
         end
      end
   end

   // adc reset bit; reserved bits stay zero
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         prst3_ff <= SMC_RST_PRST3;
      end else if (wr & h_prst & pstrb[0]) begin
         prst3_ff <= {15'h0000, pwdata[SMC_B_ADCR]};
      end
   end

   // deep selects are kept; request bits are pulses
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         drm_ff <= 1'b0;
         dpm_ff <= 1'b0;
      end else if (wr_sbyc) begin
         drm_ff <= pwdata[SMC_B_DRM];
         dpm_ff <= pwdata[SMC_B_DPM];
      end
   end

   // unlock sequence: code 5 then code A, any else restarts
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         key1_ff <= 1'b0;
         unlk_ff <= 1'b0;
      end else if (wr_unlk) begin
         key1_ff <= (pwdata[7:4] == SMC_UNLK_KEY1);
         unlk_ff <= key1_ff && (pwdata[7:4] == SMC_UNLK_KEY2);
      end else if (wr_sbyc && req_stp) begin
         key1_ff <= 1'b0;
         unlk_ff <= 1'b0; // consumed by a stop request
      end
   end

   // refused-entry status, updated on each request write
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         refused_ff <= 1'b0;
      end else if (wr_sbyc & req_any) begin
         refused_ff <= refuse;
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cpu_ff <= 1'b0;
         per_ff <= 1'b0;
         full_ff <= 1'b0;
         hs_ff <= 1'b0;
         shs_ff <= 1'b0;
         vddl_ff <= 1'b0;
         run_ff <= 1'b0;
      end else begin
         cpu_ff <= nxt_cpu;
         per_ff <= nxt_per;
         full_ff <= nxt_full & nxt_per;
         hs_ff <= nxt_hs;
         shs_ff <= nxt_shs;
         vddl_ff <= nxt_vddl;
         run_ff <= n_run;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign cpu_clk_en = cpu_ff;
   assign periph_clk_en = per_ff;
   assign full_periph_en = full_ff;
   assign hs_clk_en = hs_ff;
   assign system_clock_hs = shs_ff;
   assign vddl_low = vddl_ff;
   assign adc_block_reset = prst3_ff[SMC_B_ADCR];
   assign run_mode = run_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_halt_wr;
      wr_sbyc && in_run && req_hlt && !req_high_speed_halt_request_bit && !req_stp
         && !req_drm && !irq_pending;
   endsequence
   sequence s_in_halt;
      state_ff == SMC_HALT;
   endsequence

   property p_adc_rst;
      wr && h_prst && pstrb[0] |=> adc_block_reset == $past(pwdata[0])
         && prst3_ff[15:1] == 15'h0000;
   endproperty
   a_adc_rst: assert property (p_adc_rst)
      else $error("adc reset bit not written");

   // sampled rstn keeps the edge that releases reset out of the antecedent
   property p_boot;
      rstn && state_ff == SMC_RST |=> state_ff == SMC_RUN ##1 run_mode;
   endproperty
   a_boot: assert property (p_boot)
      else $error("reset mode did not reach run");

   property p_halt_entry;
      s_halt_wr |=> s_in_halt ##0 !cpu_clk_en;
   endproperty
   a_halt_entry: assert property (p_halt_entry)
      else $error("halt not entered");

   property p_halt_wake;
      s_in_halt ##0 irq_pending |=> run_mode && cpu_clk_en;
   endproperty
   a_halt_wake: assert property (p_halt_wake)
      else $error("halt not left after interrupt");

   property p_halth_ignore;
      wr_sbyc && in_run && req_high_speed_halt_request_bit && !sel_ff |=> state_ff == SMC_RUN;
   endproperty
   a_halth_ignore: assert property (p_halth_ignore)
      else $error("high-speed halt taken on low clock");

   property p_halth_clk;
      state_ff == SMC_HALTH |-> !hs_clk_en && !cpu_clk_en;
   endproperty
   a_halth_clk: assert property (p_halth_clk)
      else $error("high clock running in high-speed halt");

   property p_stop_lock;
      wr_sbyc && req_stp && !unlk_ff |=> state_ff != SMC_STOP
         && state_ff != SMC_STOPD;
   endproperty
   a_stop_lock: assert property (p_stop_lock)
      else $error("stop entered while locked");

   property p_stop_clk;
      state_ff == SMC_STOP && $past(state_ff) == SMC_STOP |->
         !periph_clk_en && !hs_clk_en && !cpu_clk_en;
   endproperty
   a_stop_clk: assert property (p_stop_clk)
      else $error("clock running in stop");

   property p_stop_hold;
      (state_ff == SMC_STOP || state_ff == SMC_STOPD) && !stop_wake
         |=> $stable(state_ff);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("stop left without stop wake");

   property p_vddl;
      state_ff == SMC_STOPD |-> vddl_low;
   endproperty
   a_vddl: assert property (p_vddl)
      else $error("supply not lowered in deep stop");

   property p_cancel;
      wr_sbyc && in_run && irq_pending |=> state_ff == SMC_RUN;
   endproperty
   a_cancel: assert property (p_cancel)
      else $error("entry not cancelled by pending interrupt");

endmodule : smc_standby_ctrl

// [hw/smc_pkg.sv]
package smc_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [15:0] SMC_IDX_PRST3 = 16'hF07E; // peripheral reset 3
   localparam logic [15:0] SMC_IDX_SBYC = 16'hF090; // standby control
   localparam logic [15:0] SMC_IDX_UNLK = 16'hF092; // stop unlock
   localparam logic [15:0] SMC_IDX_CLKS = 16'hF094; // clock source select
   localparam logic [15:0] SMC_IDX_STAT = 16'hF096; // mode and entry status

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SMC_B_HLT = 0; // halt request
   localparam int SMC_B_HIGH_SPEED_HALT_REQUEST_BIT = 1; // high-speed halt request
   localparam int SMC_B_STP = 2; // stop request
   localparam int SMC_B_DRM = 4; // deep mode select
   localparam int SMC_B_DPM = 5; // deep power select
   localparam int SMC_B_ADCR = 0; // adc block reset
   localparam int SMC_B_SEL = 0; // system clock source, 1 = high speed
   localparam int SMC_B_UNLK = 8; // status: stop unlocked
   localparam int SMC_B_REFU = 9; // status: last entry refused

   // ------------------------------------------------------------
   // reset values and unlock codes
   // ------------------------------------------------------------
   localparam logic [15:0] SMC_RST_PRST3 = 16'h0001;
   localparam logic [3:0] SMC_UNLK_KEY1 = 4'h5;
   localparam logic [3:0] SMC_UNLK_KEY2 = 4'hA;
   localparam logic SMC_RST_SEL = 1'b0;

   // ------------------------------------------------------------
   // operating states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      SMC_RST = 7'h01,
      SMC_RUN = 7'h02,
      SMC_HALT = 7'h04,
      SMC_HALTH = 7'h08,
      SMC_HALTD = 7'h10,
      SMC_STOP = 7'h20,
      SMC_STOPD = 7'h40
   } smc_state_e;

endpackage : smc_pkg

// [bench/smc_wake_src.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// wake source model: cpu interrupt and stop wake requests
// ------------------------------------------------------------
module smc_wake_src (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic irq_req, // bench asks for a cpu interrupt
   input wire logic wake_req, // bench asks for a stop wake event
   input wire logic [1:0] dly, // answer delay in cycles
   output logic irq_pending,
   output logic stop_wake
);
   logic [1:0] cnt_ff; // cycles since the request began
   logic [1:0] nxt_cnt;
   logic req; // any request standing
   logic due; // requested delay has run out
   assign req = irq_req | wake_req;
   assign due = (cnt_ff == dly);
   // count up to the delay, then hold; clear when withdrawn
   assign nxt_cnt = !req ? 2'h0 : due ? cnt_ff : cnt_ff + 2'h1;
   // levels held until the bench withdraws them
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_ff <= 2'h0;
         irq_pending <= 1'b0;
         stop_wake <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         irq_pending <= irq_req & due; // enabled irq or watchdog
         stop_wake <= wake_req & due; // external, supervisor, i2c slave
      end
   end
endmodule : smc_wake_src

// [bench/smc_standby_ctrl_test.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
   end \
end
module smc_standby_ctrl_test;
   import smc_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [19:0] paddr = 20'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, irq_pending, stop_wake;
   logic cpu_clk_en, periph_clk_en, full_periph_en, hs_clk_en;
   logic system_clock_hs, vddl_low, adc_block_reset, run_mode;
   logic irq_req = 1'b0; // wake model controls
   logic wake_req = 1'b0;
   logic [1:0] dly = 2'h0;
   logic [31:0] seed = 32'hFA6DC010; // xorshift state
   logic [31:0] q; // last read data
   logic e; // last error response
   logic [2:0] m; // mode under test
   logic sel; // clock source before entry
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   always #2.5 sys_clk = ~sys_clk;
   smc_standby_ctrl DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_pending(irq_pending), .stop_wake(stop_wake),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .full_periph_en(full_periph_en), .hs_clk_en(hs_clk_en),
      .system_clock_hs(system_clock_hs), .vddl_low(vddl_low),
      .adc_block_reset(adc_block_reset), .run_mode(run_mode));
   smc_wake_src wake_src (.sys_clk(sys_clk), .rstn(rstn),
      .irq_req(irq_req), .wake_req(wake_req), .dly(dly),
      .irq_pending(irq_pending), .stop_wake(stop_wake));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // expected {periph, full periph, high clock, low supply} in mode m
   function automatic logic [3:0] exp_in(input logic [2:0] mm,
                                         input logic sl);
      return {mm < 3'h3, mm < 3'h2, mm == 3'h0 && sl, mm == 3'h4};
   endfunction : exp_in
   // one apb transfer, waits for pready under a bound
   task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) fail_count++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   // raise a wake source, check return at the sampling edge
   task wake(input logic stop_request_bit);
      int n;
      @(posedge sys_clk);
      seed = xs(seed);
      dly <= seed[1:0];
      if (stop_request_bit) wake_req <= 1'b1;
      else irq_req <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((stop_request_bit ? stop_wake : irq_pending) !== 1'b1 && n < 10);
      #1;
      `CHK("run_mode", 1'b1, run_mode)
      wake_req <= 1'b0;
      irq_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : wake
   // verdict and end of run
   task summarize;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("run_mode", 1'b1, run_mode)
      `CHK("adc_rst", 1'b1, adc_block_reset)
      apb(1'b0, SMC_IDX_PRST3, 32'h0);
      `CHK("prst3", 32'h1, q)
      apb(1'b1, SMC_IDX_PRST3, 32'hFFFF_FFFE);
      `CHK("adc_rst", 1'b0, adc_block_reset)
      apb(1'b0, SMC_IDX_PRST3, 32'h0);
      `CHK("prst3", 32'h0, q)
      apb(1'b1, SMC_IDX_PRST3, 32'hFFFF_FFFF);
      apb(1'b0, SMC_IDX_PRST3, 32'h0);
      `CHK("prst3", 32'h1, q)
      // unmapped place answers with an error and zero data
      apb(1'b0, 16'h0123, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {e, q})
      // high-speed halt on the low clock is ignored
      apb(1'b1, SMC_IDX_CLKS, 32'h0);
      apb(1'b1, SMC_IDX_SBYC, 32'h2);
      `CHK("run_mode", 1'b1, run_mode)
      apb(1'b0, SMC_IDX_STAT, 32'h0);
      `CHK("refused", 1'b1, q[SMC_B_REFU])
      // stop without the unlock codes is refused
      apb(1'b1, SMC_IDX_SBYC, 32'h4);
      `CHK("run_mode", 1'b1, run_mode)
      apb(1'b0, SMC_IDX_STAT, 32'h0);
      `CHK("lock", 2'h2, {q[SMC_B_REFU], q[SMC_B_UNLK]})
      // pending interrupt cancels a halt entry
      @(posedge sys_clk);
      irq_req <= 1'b1;
      repeat (4) @(posedge sys_clk);
      apb(1'b1, SMC_IDX_SBYC, 32'h1);
      `CHK("run_mode", 1'b1, run_mode)
      irq_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
      // every mode, random source, codes and deep power bit
      for (int i = 0; i < 15; i++) begin
         seed = xs(seed);
         m = 3'(i % 5);
         sel = (m == 3'h1) ? 1'b1 : seed[3];
         apb(1'b1, SMC_IDX_CLKS, {31'h0, sel});
         if (m >= 3'h3) begin
            apb(1'b1, SMC_IDX_UNLK, {24'h0, 4'h5, seed[7:4]});
            apb(1'b1, SMC_IDX_UNLK, {24'h0, 4'hA, seed[11:8]});
            apb(1'b0, SMC_IDX_STAT, 32'h0);
            `CHK("unlocked", 1'b1, q[SMC_B_UNLK])
         end
         case (m)
            3'h0: q = 32'h01;
            3'h1: q = 32'h02;
            3'h2: q = 32'h11;
            3'h3: q = 32'h04;
            default: q = 32'h14;
         endcase
         apb(1'b1, SMC_IDX_SBYC, q | {26'h0, seed[12], 5'h0});
         `CHK("run_mode", 1'b0, run_mode)
         `CHK("cpu_clk", 1'b0, cpu_clk_en)
         `CHK("in_mode", exp_in(m, sel), {periph_clk_en, full_periph_en,
            hs_clk_en, vddl_low})
         `CHK("src_in", m == 3'h0 && sel, system_clock_hs)
         apb(1'b0, SMC_IDX_SBYC, 32'h0);
         `CHK("sbyc", {seed[12], m == 3'h2 || m == 3'h4, 4'h0}, q[5:0])
         apb(1'b0, SMC_IDX_STAT, 32'h0);
         `CHK("state", 7'h04 << m, q[6:0])
         if (m >= 3'h3) begin
            @(posedge sys_clk);
            irq_req <= 1'b1;
            repeat (5) @(posedge sys_clk);
            #1;
            `CHK("run_mode", 1'b0, run_mode)
            irq_req <= 1'b0;
            repeat (3) @(posedge sys_clk);
         end
         wake(m >= 3'h3);
         `CHK("cpu_clk", 1'b1, cpu_clk_en)
         `CHK("src", sel, system_clock_hs)
         `CHK("hs_clk", sel, hs_clk_en)
      end
      summarize();
   end
endmodule : smc_standby_ctrl_test
